// [shared/tas_pkg.sv]
// Package: constants, types and register map of the acquisition sequencer
package tas_pkg;

    localparam int unsigned DATA_W = 32;
    localparam int unsigned ADDR_W = 6;
    localparam int unsigned SMP_W = 16;
    localparam int unsigned BUF_AW = 12;
    localparam int unsigned CNT_W = 13;
    localparam int unsigned BUF_DEPTH = 4096;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] REG_CTRL = 6'h00;
    localparam logic [ADDR_W-1:0] REG_CONFIG = 6'h04;
    localparam logic [ADDR_W-1:0] REG_LEVEL = 6'h08;
    localparam logic [ADDR_W-1:0] REG_HYST = 6'h0c;
    localparam logic [ADDR_W-1:0] REG_POINTS = 6'h10;
    localparam logic [ADDR_W-1:0] REG_COUNT = 6'h14;
    localparam logic [ADDR_W-1:0] REG_OFFSET = 6'h18;
    localparam logic [ADDR_W-1:0] REG_INTERVAL = 6'h1c;
    localparam logic [ADDR_W-1:0] REG_STATUS = 6'h20;
    localparam logic [ADDR_W-1:0] REG_RD_ADDR = 6'h24;
    localparam logic [ADDR_W-1:0] REG_RD_DATA = 6'h28;
    localparam logic [ADDR_W-1:0] REG_REC_START = 6'h2c;

    // Command bits of REG_CTRL (write only, self clearing)
    localparam int unsigned CTRL_INIT = 0;
    localparam int unsigned CTRL_ABORT = 1;
    localparam int unsigned CTRL_BUS_TRIG = 2;
    localparam int unsigned CTRL_IMM_TRIG = 3;
    localparam int unsigned CTRL_OPC_REQ = 4;

    // Field positions of REG_CONFIG and REG_STATUS
    localparam int unsigned CFG_SRC_LSB = 0;
    localparam int unsigned CFG_FUNC_LSB = 2;
    localparam int unsigned CFG_SLOPE_LSB = 4;
    localparam int unsigned STAT_STATE_LSB = 0;
    localparam int unsigned STAT_ERR = 4;
    localparam int unsigned STAT_OPC = 5;
    localparam int unsigned STAT_ACQ_LSB = 16;

    // Reset values
    localparam logic [CNT_W-1:0] RST_POINTS = 13'h0400;
    localparam logic [CNT_W-1:0] RST_COUNT = 13'h0001;
    localparam logic [15:0] RST_INTERVAL = 16'h0001;
    localparam logic [SMP_W-1:0] RST_LEVEL = 16'h0000;
    localparam logic [SMP_W-1:0] RST_HYST = 16'h0000;

    // Fixed aux voltmeter record
    localparam logic [CNT_W-1:0] AUX_POINTS = 13'h0800;
    localparam int unsigned CLK_PERIOD_PS = 20000;
    localparam int unsigned AUX_PERIOD_PS = 15600000;
    localparam logic [15:0] AUX_INTERVAL = 16'(AUX_PERIOD_PS / CLK_PERIOD_PS);

    // Offset limits
    localparam logic signed [31:0] OFFSET_MIN = -32'sd4095;
    localparam logic signed [31:0] OFFSET_MAX = 32'sd2000000000;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_ARMED = 4'b0010,
        ST_DELAY = 4'b0100,
        ST_CAPTURE = 4'b1000
    } tas_state_t;

    typedef enum logic [1:0] {SRC_BUS = 2'h0, SRC_INT = 2'h1, SRC_EXT = 2'h2} tas_src_t;
    typedef enum logic [1:0] {FN_CURR = 2'h0, FN_VOLT = 2'h1, FN_AUX = 2'h2} tas_func_t;
    typedef enum logic [1:0] {SL_POS = 2'h0, SL_NEG = 2'h1, SL_EITHER = 2'h2} tas_slope_t;

    typedef struct packed {
        logic read;
        logic write;
        logic [ADDR_W-1:0] address;
        logic [DATA_W-1:0] writedata;
        logic [3:0] byteenable;
    } tas_avs_req_t;

endpackage

// [hdl/tas_seq.sv]
// Triggered acquisition sequencer with Avalon-MM register slave
//
// What this block does
// - After reset the sequencer idles with triggers disabled and ignores every trigger.
// - Abort, device reset or settings recall force idle at once from any state.
// - Only an initiate command arms the sequencer; triggers count only when armed.
// - After acquisition, return to idle unless counted acquisitions remain; never self re-arm.
// - Trigger source is one of bus command, internal detector or external input.
// - Immediate trigger always fires; bus trigger or group execute fire with bus source.
// - External source triggers on the falling edge of the external input.
// - Exactly one sensing function runs: current, voltage or aux voltmeter input.
// - Detector uses one programmable level for both rising and falling crossings.
// - Detector slope selects rising only, falling only, or either direction.
// - A crossing counts only after the signal has moved through the hysteresis band.
// - A result fetch during an acquisition is held off until it completes.
// - Operation-complete requested after initiate sets its event bit when acquisition ends.
// - Count above one runs acquisitions back to back, each awaiting a fresh trigger.
// - Counts above one are refused for the aux voltmeter function.
// - Error when count times points exceeds the 4096 sample buffer.
// - Sampling runs continuously from initiation so pre-trigger samples exist.
// - Signed offset from -4095 to 2000000000; negative gives pre-trigger samples.
// - Positive offset delays first stored sample by offset sample periods.
// - Triggers before the pre-trigger samples are collected are ignored.
// - Aux voltmeter records are fixed at 2048 samples every 15.6 us.
//
// Our own choices: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps
module tas_seq #(
    parameter int unsigned BUF_DEPTH = tas_pkg::BUF_DEPTH
) (
    input wire logic I_CLK_SYS,
    input wire logic I_RST_B,
    input wire tas_pkg::tas_avs_req_t I_AVS,
    output logic [31:0] O_AVS_READDATA,
    output logic O_AVS_WAITREQUEST,
    input wire logic signed [15:0] I_SAMPLE_DATA,
    input wire logic I_BUS_GET,
    input wire logic I_DEV_RESET,
    input wire logic I_RECALL,
    input wire logic I_EXT_TRIG_B,
    output logic [1:0] O_FUNC_SEL,
    output logic O_BUSY,
    output logic O_OPC_EVENT,
    output logic O_ERROR
);

    typedef struct packed {
        tas_pkg::tas_state_t state;
        logic [1:0] src;
        logic [1:0] func;
        logic [1:0] slope;
        logic signed [15:0] level;
        logic [15:0] hyst;
        logic [12:0] points;
        logic [12:0] count;
        logic signed [31:0] offset;
        logic [15:0] interval;
        logic [11:0] rd_addr;
        logic err;
        logic opc_evt;
        logic opc_armed;
        logic wait_r;
        logic [31:0] rdata;
        logic [15:0] tick_cnt;
        logic smp_vld;
        logic signed [15:0] smp;
        logic det_below;
        logic det_above;
        logic det_pulse;
        logic ext_s1;
        logic ext_s2;
        logic ext_s3;
        logic [12:0] run_points;
        logic [12:0] run_count;
        logic [12:0] run_pre;
        logic [30:0] run_dly;
        logic [15:0] run_ivl;
        logic [12:0] pre_cnt;
        logic [11:0] wp;
        logic [12:0] post_cnt;
        logic [30:0] dly_cnt;
        logic [12:0] acq_idx;
        logic [11:0] base;
        logic [11:0] rec_start;
        logic mem_we;
        logic [11:0] mem_addr;
        logic [15:0] mem_din;
    } tas_regs_t;

    tas_regs_t st_reg;
    tas_regs_t st_next;
    logic [15:0] mem [BUF_DEPTH];

    function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // Sign extension to 18 bits so level plus band cannot wrap
    function automatic logic signed [17:0] sx(input logic signed [15:0] a);
        return {{2{a[15]}}, a};
    endfunction

    logic req;
    logic wr_take;
    logic [31:0] wval;
    logic rd_stall;
    logic [31:0] rd_mux;
    logic trig;
    logic ext_fall;
    logic signed [17:0] lvl_hi;
    logic signed [17:0] lvl_lo;
    logic rise_hit;
    logic fall_hit;
    logic [25:0] total_pts;
    logic [12:0] e_points;
    logic [12:0] e_pre;
    logic init_bad;
    logic cmd_init;
    logic cmd_abort;
    logic cmd_bus;
    logic cmd_imm;
    logic cmd_opc;
    logic tick;

    always_comb begin
        st_next = st_reg;
        req = I_AVS.read | I_AVS.write;
        wr_take = I_AVS.write & ~st_reg.wait_r;
        cmd_init = wr_take && I_AVS.address == tas_pkg::REG_CTRL && I_AVS.byteenable[0] &&
                   I_AVS.writedata[tas_pkg::CTRL_INIT];
        cmd_abort = wr_take && I_AVS.address == tas_pkg::REG_CTRL && I_AVS.byteenable[0] &&
                    I_AVS.writedata[tas_pkg::CTRL_ABORT];
        cmd_bus = wr_take && I_AVS.address == tas_pkg::REG_CTRL && I_AVS.byteenable[0] &&
                  I_AVS.writedata[tas_pkg::CTRL_BUS_TRIG];
        cmd_imm = wr_take && I_AVS.address == tas_pkg::REG_CTRL && I_AVS.byteenable[0] &&
                  I_AVS.writedata[tas_pkg::CTRL_IMM_TRIG];
        cmd_opc = wr_take && I_AVS.address == tas_pkg::REG_CTRL && I_AVS.byteenable[0] &&
                  I_AVS.writedata[tas_pkg::CTRL_OPC_REQ];

        // Fetch of buffer data waits while an acquisition is running
        rd_stall = I_AVS.read && I_AVS.address == tas_pkg::REG_RD_DATA && st_reg.state != tas_pkg::ST_IDLE;

        case (I_AVS.address)
            tas_pkg::REG_CONFIG: rd_mux = {26'h0, st_reg.slope, st_reg.func, st_reg.src};
            tas_pkg::REG_LEVEL: rd_mux = {{16{st_reg.level[15]}}, st_reg.level};
            tas_pkg::REG_HYST: rd_mux = {16'h0, st_reg.hyst};
            tas_pkg::REG_POINTS: rd_mux = {19'h0, st_reg.points};
            tas_pkg::REG_COUNT: rd_mux = {19'h0, st_reg.count};
            tas_pkg::REG_OFFSET: rd_mux = st_reg.offset;
            tas_pkg::REG_INTERVAL: rd_mux = {16'h0, st_reg.interval};
            tas_pkg::REG_STATUS: rd_mux = {3'h0, st_reg.acq_idx, 10'h0, st_reg.opc_evt, st_reg.err, st_reg.state};
            tas_pkg::REG_RD_ADDR: rd_mux = {20'h0, st_reg.rd_addr};
            tas_pkg::REG_RD_DATA: rd_mux = {16'h0, mem[st_reg.rd_addr]};
            tas_pkg::REG_REC_START: rd_mux = {20'h0, st_reg.rec_start};
            default: rd_mux = 32'h0;
        endcase
        wval = be_merge(rd_mux, I_AVS.writedata, I_AVS.byteenable);

        // Bus handshake: one cycle of waitrequest low per accepted request
        if (req && st_reg.wait_r && !rd_stall) begin
            st_next.wait_r = 1'b0;
            st_next.rdata = I_AVS.read ? rd_mux : 32'h0;
        end else begin
            st_next.wait_r = 1'b1;
        end

        if (wr_take) begin
            case (I_AVS.address)
                tas_pkg::REG_CONFIG: begin
                    // One function at a time; code 3 names none and is refused
                    st_next.func = wval[tas_pkg::CFG_FUNC_LSB +: 2] == 2'h3 ? st_reg.func :
                                   wval[tas_pkg::CFG_FUNC_LSB +: 2];
                    st_next.src = wval[tas_pkg::CFG_SRC_LSB +: 2];
                    st_next.slope = wval[tas_pkg::CFG_SLOPE_LSB +: 2];
                end
                tas_pkg::REG_LEVEL: st_next.level = wval[15:0];
                tas_pkg::REG_HYST: st_next.hyst = wval[15:0];
                tas_pkg::REG_POINTS: st_next.points = wval[12:0];
                tas_pkg::REG_COUNT: st_next.count = wval[12:0];
                tas_pkg::REG_OFFSET: begin
                    // Out of range offsets are refused and flagged
                    if ($signed(wval) < tas_pkg::OFFSET_MIN || $signed(wval) > tas_pkg::OFFSET_MAX) begin
                        st_next.err = 1'b1;
                    end else begin
                        st_next.offset = wval;
                    end
                end
                tas_pkg::REG_INTERVAL: st_next.interval = (wval[15:0] == 16'h0) ? 16'h1 : wval[15:0];
                tas_pkg::REG_RD_ADDR: st_next.rd_addr = wval[11:0];
                tas_pkg::REG_STATUS: begin
                    if (I_AVS.byteenable[0] && I_AVS.writedata[tas_pkg::STAT_ERR]) begin
                        st_next.err = 1'b0;
                    end
                    if (I_AVS.byteenable[0] && I_AVS.writedata[tas_pkg::STAT_OPC]) begin
                        st_next.opc_evt = 1'b0;
                    end
                end
                default: ;
            endcase
        end

        // External pin: two-stage synchroniser, then falling edge
        st_next.ext_s1 = I_EXT_TRIG_B;
        st_next.ext_s2 = st_reg.ext_s1;
        st_next.ext_s3 = st_reg.ext_s2;
        ext_fall = st_reg.ext_s3 & ~st_reg.ext_s2;

        // Sample clock runs only while the sequencer is out of idle
        tick = 1'b0;
        st_next.smp_vld = 1'b0;
        if (st_reg.state == tas_pkg::ST_IDLE) begin
            st_next.tick_cnt = 16'h0;
        end else if (st_reg.tick_cnt == 16'h0) begin
            tick = 1'b1;
            st_next.tick_cnt = st_reg.run_ivl - 16'h1;
        end else begin
            st_next.tick_cnt = st_reg.tick_cnt - 16'h1;
        end
        if (tick) begin
            st_next.smp = I_SAMPLE_DATA;
            st_next.smp_vld = 1'b1;
        end

        // Level detector with hysteresis, evaluated per sample
        lvl_hi = sx(st_reg.level) + $signed({2'b00, st_reg.hyst});
        lvl_lo = sx(st_reg.level) - $signed({2'b00, st_reg.hyst});
        rise_hit = st_reg.det_below && sx(st_reg.smp) >= sx(st_reg.level);
        fall_hit = st_reg.det_above && sx(st_reg.smp) <= sx(st_reg.level);
        st_next.det_pulse = 1'b0;
        if (st_reg.smp_vld && st_reg.state != tas_pkg::ST_IDLE) begin
            // A crossing is armed only once the signal left the band on the far side
            if (sx(st_reg.smp) <= lvl_lo) begin
                st_next.det_below = 1'b1;
            end else if (rise_hit) begin
                st_next.det_below = 1'b0;
            end
            if (sx(st_reg.smp) >= lvl_hi) begin
                st_next.det_above = 1'b1;
            end else if (fall_hit) begin
                st_next.det_above = 1'b0;
            end
            case (st_reg.slope)
                tas_pkg::SL_POS: st_next.det_pulse = rise_hit;
                tas_pkg::SL_NEG: st_next.det_pulse = fall_hit;
                tas_pkg::SL_EITHER: st_next.det_pulse = rise_hit | fall_hit;
                default: st_next.det_pulse = 1'b0;
            endcase
        end

        trig = cmd_imm;
        case (st_reg.src)
            tas_pkg::SRC_BUS: trig = trig | cmd_bus | I_BUS_GET;
            tas_pkg::SRC_INT: trig = trig | st_reg.det_pulse;
            tas_pkg::SRC_EXT: trig = trig | ext_fall;
            default: trig = trig;
        endcase

        // Effective record shape; aux records are fixed
        if (st_reg.func == tas_pkg::FN_AUX) begin
            e_points = tas_pkg::AUX_POINTS;
            e_pre = 13'h0;
        end else begin
            e_points = st_reg.points;
            e_pre = st_reg.offset[31] ? 13'(-st_reg.offset) : 13'h0;
        end
        total_pts = 26'(st_reg.count) * 26'(e_points);
        init_bad = total_pts > 26'(BUF_DEPTH)
                || (st_reg.func == tas_pkg::FN_AUX && st_reg.count > 13'h1)
                || st_reg.count == 13'h0 || e_points == 13'h0 || e_pre > e_points
                || st_reg.func > tas_pkg::FN_AUX;

        st_next.mem_we = 1'b0;
        case (st_reg.state)
            tas_pkg::ST_IDLE: begin
                // Triggers are never looked at here
                if (cmd_init) begin
                    if (init_bad) begin
                        st_next.err = 1'b1;
                    end else begin
                        st_next.state = tas_pkg::ST_ARMED;
                        st_next.run_points = e_points;
                        st_next.run_count = st_reg.func == tas_pkg::FN_AUX ? 13'h1 : st_reg.count;
                        st_next.run_pre = e_pre;
                        st_next.run_dly = (st_reg.func != tas_pkg::FN_AUX && !st_reg.offset[31]) ?
                                          st_reg.offset[30:0] : 31'h0;
                        st_next.run_ivl = st_reg.func == tas_pkg::FN_AUX ? tas_pkg::AUX_INTERVAL :
                                          st_reg.interval;
                        st_next.acq_idx = 13'h0;
                        st_next.base = 12'h0;
                        st_next.pre_cnt = 13'h0;
                        st_next.wp = 12'h0;
                        st_next.det_below = 1'b0;
                        st_next.det_above = 1'b0;
                    end
                end
            end
            tas_pkg::ST_ARMED: begin
                // Pre-trigger samples fill a ring at the head of the record
                if (st_reg.smp_vld && st_reg.run_pre != 13'h0) begin
                    st_next.mem_we = 1'b1;
                    st_next.mem_addr = st_reg.base + st_reg.wp;
                    st_next.mem_din = st_reg.smp;
                    st_next.wp = (13'(st_reg.wp) == st_reg.run_pre - 13'h1) ? 12'h0 : st_reg.wp + 12'h1;
                    if (st_reg.pre_cnt < st_reg.run_pre) begin
                        st_next.pre_cnt = st_reg.pre_cnt + 13'h1;
                    end
                end
                // Early triggers are dropped; a later one is still awaited
                if (trig && st_reg.pre_cnt >= st_reg.run_pre) begin
                    st_next.rec_start = st_next.wp; // Oldest entry, counting a write this cycle
                    st_next.post_cnt = 13'h0;
                    st_next.dly_cnt = st_reg.run_dly;
                    st_next.state = st_reg.run_dly != 31'h0 ? tas_pkg::ST_DELAY : tas_pkg::ST_CAPTURE;
                end
            end
            tas_pkg::ST_DELAY: begin
                // Samples inside the delay are discarded
                if (st_reg.smp_vld) begin
                    st_next.dly_cnt = st_reg.dly_cnt - 31'h1;
                    if (st_reg.dly_cnt == 31'h1) begin
                        st_next.state = tas_pkg::ST_CAPTURE;
                    end
                end
            end
            tas_pkg::ST_CAPTURE: begin
                if (st_reg.post_cnt >= st_reg.run_points - st_reg.run_pre) begin
                    if (st_reg.acq_idx + 13'h1 < st_reg.run_count) begin
                        // Next record waits for a fresh trigger of its own
                        st_next.acq_idx = st_reg.acq_idx + 13'h1;
                        st_next.base = st_reg.base + st_reg.run_points[11:0];
                        st_next.pre_cnt = 13'h0;
                        st_next.wp = 12'h0;
                        st_next.state = tas_pkg::ST_ARMED;
                    end else begin
                        st_next.acq_idx = st_reg.acq_idx + 13'h1;
                        st_next.state = tas_pkg::ST_IDLE;
                        if (st_reg.opc_armed) begin
                            st_next.opc_evt = 1'b1;
                            st_next.opc_armed = 1'b0;
                        end
                    end
                end else if (st_reg.smp_vld) begin
                    st_next.mem_we = 1'b1;
                    st_next.mem_addr = 12'(st_reg.base + 12'(st_reg.run_pre) + 12'(st_reg.post_cnt));
                    st_next.mem_din = st_reg.smp;
                    st_next.post_cnt = st_reg.post_cnt + 13'h1;
                end
            end
            default: st_next.state = tas_pkg::ST_IDLE;
        endcase

        // Completion request only counts once the sequencer has left idle
        if (cmd_opc && st_next.state != tas_pkg::ST_IDLE) begin
            st_next.opc_armed = 1'b1;
        end

        if (cmd_abort || I_DEV_RESET || I_RECALL) begin
            st_next.state = tas_pkg::ST_IDLE;
            st_next.opc_armed = 1'b0;
            st_next.mem_we = 1'b0;
        end
    end

    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RST_B) begin
            st_reg <= '0;
            st_reg.state <= tas_pkg::ST_IDLE;
            st_reg.wait_r <= 1'b1;
            st_reg.points <= tas_pkg::RST_POINTS;
            st_reg.count <= tas_pkg::RST_COUNT;
            st_reg.interval <= tas_pkg::RST_INTERVAL;
            st_reg.level <= tas_pkg::RST_LEVEL;
            st_reg.hyst <= tas_pkg::RST_HYST;
            st_reg.run_ivl <= tas_pkg::RST_INTERVAL;
            st_reg.ext_s1 <= 1'b1;
            st_reg.ext_s2 <= 1'b1;
            st_reg.ext_s3 <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    // Buffer kept outside the state record; contents need no reset
    always_ff @(posedge I_CLK_SYS) begin
        if (st_reg.mem_we) begin
            mem[st_reg.mem_addr] <= st_reg.mem_din;
        end
    end

    always_comb begin
        O_AVS_READDATA = st_reg.rdata;
        O_AVS_WAITREQUEST = st_reg.wait_r;
        O_FUNC_SEL = st_reg.func;
        O_BUSY = st_reg.state != tas_pkg::ST_IDLE;
        O_OPC_EVENT = st_reg.opc_evt;
        O_ERROR = st_reg.err;
    end

endmodule

// [tb/tas_seq_assertions.sv]
// Concurrent checks on the acquisition sequencer ports
`timescale 1ns/1ps
module tas_seq_chk #(
    parameter int unsigned BUF_DEPTH = tas_pkg::BUF_DEPTH
) (
    input wire logic I_CLK_SYS,
    input wire logic I_RST_B,
    input wire tas_pkg::tas_avs_req_t I_AVS,
    input wire logic O_AVS_WAITREQUEST,
    input wire logic I_DEV_RESET,
    input wire logic I_RECALL,
    input wire logic [1:0] O_FUNC_SEL,
    input wire logic O_BUSY,
    input wire logic O_OPC_EVENT,
    input wire logic O_ERROR
);
    default clocking @(posedge I_CLK_SYS); endclocking
    default disable iff (!I_RST_B);
    AST_RST_IDLE: assert property ($rose(I_RST_B) |-> !O_BUSY && !O_OPC_EVENT && !O_ERROR)
        else $error("outputs not idle after reset");
    AST_DEVRST_IDLE: assert property (I_DEV_RESET |=> !O_BUSY)
        else $error("device reset left sequencer busy");
    AST_RECALL_IDLE: assert property (I_RECALL |=> !O_BUSY)
        else $error("recall left sequencer busy");
    AST_ARM_BY_WRITE: assert property ($rose(O_BUSY) |-> $past(I_AVS.write, 1) || $past(I_AVS.write, 2))
        else $error("busy rose without a register write");
    AST_NO_REARM: assert property ($fell(O_BUSY) |-> !O_BUSY [*2])
        else $error("sequencer re-armed by itself");
    AST_FUNC_ONE: assert property (O_FUNC_SEL != 2'h3)
        else $error("illegal sensing function");
    AST_FETCH_HOLD: assert property (O_BUSY && I_AVS.read && I_AVS.address == tas_pkg::REG_RD_DATA
        |-> O_AVS_WAITREQUEST)
        else $error("result read answered while busy");
    AST_OPC_AT_END: assert property ($rose(O_OPC_EVENT) |-> !O_BUSY)
        else $error("completion flagged while busy");
    AST_ERR_STICKY: assert property (O_ERROR && !(I_AVS.write && I_AVS.address == tas_pkg::REG_STATUS)
        |=> O_ERROR)
        else $error("error flag dropped without clear");
endmodule
bind tas_seq tas_seq_chk #(.BUF_DEPTH(BUF_DEPTH)) tas_seq_chk_inst (.I_CLK_SYS(I_CLK_SYS), .I_RST_B(I_RST_B),
    .I_AVS(I_AVS), .O_AVS_WAITREQUEST(O_AVS_WAITREQUEST), .I_DEV_RESET(I_DEV_RESET), .I_RECALL(I_RECALL),
    .O_FUNC_SEL(O_FUNC_SEL), .O_BUSY(O_BUSY), .O_OPC_EVENT(O_OPC_EVENT), .O_ERROR(O_ERROR));

// [tb/tas_sig_src.sv]
// Sensed signal and external trigger pin model
`timescale 1ns/1ps
module tas_sig_src (
    input wire logic i_clk,
    input wire logic i_fire,
    output logic signed [15:0] o_sample,
    output logic o_ext_trig_b
);
    initial o_sample = '0;
    // Sawtooth: slow rise, sharp fall, so both slopes cross zero
    always @(posedge i_clk) o_sample <= (o_sample > 16'sd200) ? -16'sd200 : o_sample + 16'sd4;
    assign o_ext_trig_b = !i_fire; // Closure pulls low, pull-up otherwise
endmodule

// [tb/tas_seq_tb_top.sv]
// Testbench top for the acquisition sequencer
`timescale 1ns/1ps
module tas_seq_tb_top;
    logic clk = 1'b0, rst_b = 1'b0, wreq, ext_b, busy, opc, err;
    logic bus_get = 1'b0, dev_rst = 1'b0, recall = 1'b0, fire = 1'b0;
    tas_pkg::tas_avs_req_t avs = '0;
    logic [31:0] rdata, q;
    logic signed [15:0] smp;
    logic [1:0] func;
    int failures = 0;
    int checked = 0;
    tas_seq tas_seq_inst (.I_CLK_SYS(clk), .I_RST_B(rst_b), .I_AVS(avs), .O_AVS_READDATA(rdata),
        .O_AVS_WAITREQUEST(wreq), .I_SAMPLE_DATA(smp), .I_BUS_GET(bus_get), .I_DEV_RESET(dev_rst),
        .I_RECALL(recall), .I_EXT_TRIG_B(ext_b), .O_FUNC_SEL(func), .O_BUSY(busy), .O_OPC_EVENT(opc), .O_ERROR(err));
    tas_sig_src tas_sig_src_inst (.i_clk(clk), .i_fire(fire), .o_sample(smp), .o_ext_trig_b(ext_b));
    initial forever #10 clk = ~clk;
    task chk(input string n, input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask
    // Request held until waitrequest seen low, then one idle edge
    task bus(input logic w, input logic [5:0] a, input logic [31:0] d);
        avs <= '{read: !w, write: w, address: a, writedata: d, byteenable: 4'hf};
        do @(posedge clk); while (wreq !== 1'b0);
        q = rdata;
        avs <= '0;
        @(posedge clk);
    endtask
    // 0 group trigger, 1 pin closure, 2 device reset, 3 recall
    task pulse(input int k);
        {recall, dev_rst, fire, bus_get} <= 4'h1 << k;
        @(posedge clk);
        {recall, dev_rst, fire, bus_get} <= 4'h0;
        @(posedge clk);
    endtask
    task cfg(input logic [31:0] c, p, n, o);
        bus(1, tas_pkg::REG_CONFIG, c);
        chk("func", 32'(func), 32'(c[3:2]));
        bus(1, tas_pkg::REG_POINTS, p);
        bus(1, tas_pkg::REG_COUNT, n);
        bus(1, tas_pkg::REG_OFFSET, o);
        bus(1, tas_pkg::REG_CTRL, 32'h11);
    endtask
    task idle();
        for (int n = 0; n < 5000 && busy !== 1'b0; n++) @(posedge clk);
        chk("busy", busy, 0);
    endtask
    task print_verdict();
        $display("checks %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task t_idle();
        pulse(0);
        bus(1, tas_pkg::REG_CTRL, 32'h4);
        chk("idle", busy, 0);
        bus(0, 6'h3c, 0);
        chk("unmapped", q, 0);
        $display("t_idle done");
    endtask
    task t_bus();
        cfg(0, 8, 1, 0);
        chk("armed", busy, 1);
        fork
            bus(0, tas_pkg::REG_RD_DATA, 0);
            begin
                repeat (6) @(posedge clk);
                pulse(0);
            end
        join
        chk("held", busy, 0);
        chk("opc", opc, 1);
        $display("t_bus done");
    endtask
    // Early trigger is lost while pre-trigger samples are still filling
    task t_cnt();
        cfg(0, 8, 2, -6);
        pulse(0);
        repeat (40) @(posedge clk);
        chk("early", busy, 1);
        bus(0, tas_pkg::REG_STATUS, 0);
        chk("none", q[28:16], 0);
        pulse(0);
        repeat (40) @(posedge clk);
        chk("second", busy, 1);
        pulse(0);
        idle();
        bus(0, tas_pkg::REG_STATUS, 0);
        chk("records", q[28:16], 2);
        // Delay of 20 samples keeps the record open past eight samples
        cfg(0, 8, 1, 20);
        bus(1, tas_pkg::REG_CTRL, 32'h4);
        repeat (15) @(posedge clk);
        chk("delay", busy, 1);
        idle();
        $display("t_cnt done");
    endtask
    task t_src();
        cfg(2, 8, 1, 0);
        bus(1, tas_pkg::REG_CTRL, 32'h4);
        chk("ext only", busy, 1);
        pulse(1);
        idle();
        cfg(2, 8, 1, 0);
        bus(1, tas_pkg::REG_CTRL, 32'h8);
        idle();
        bus(1, tas_pkg::REG_HYST, 10);
        for (int s = 0; s < 3; s++) begin
            cfg(32'h1 | (s << 4), 8, 1, 0);
            idle();
        end
        // Band wider than the sawtooth swing never qualifies a crossing
        bus(1, tas_pkg::REG_HYST, 300);
        cfg(32'h21, 8, 1, 0);
        repeat (300) @(posedge clk);
        chk("band", busy, 1);
        bus(1, tas_pkg::REG_CTRL, 32'h2);
        $display("t_src done");
    endtask
    task t_err();
        bus(1, tas_pkg::REG_CONFIG, 32'hc);
        chk("func3", func, 0);
        cfg(0, 2048, 3, 0);
        chk("over", err, 1);
        bus(1, tas_pkg::REG_STATUS, 32'h10);
        cfg(8, 8, 2, 0);
        chk("aux", err, 1);
        bus(1, tas_pkg::REG_STATUS, 32'h10);
        bus(1, tas_pkg::REG_OFFSET, -4096);
        chk("offset", err, 1);
        bus(1, tas_pkg::REG_STATUS, 32'h10);
        chk("clear", err, 0);
        $display("t_err done");
    endtask
    task t_abort();
        cfg(0, 8, 1, 0);
        bus(1, tas_pkg::REG_CTRL, 32'h2);
        chk("abort", busy, 0);
        cfg(0, 8, 1, 0);
        pulse(2);
        chk("devrst", busy, 0);
        cfg(0, 8, 1, 0);
        pulse(3);
        chk("recall", busy, 0);
        $display("t_abort done");
    endtask
    initial begin
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        t_idle();
        t_bus();
        t_cnt();
        t_src();
        t_err();
        t_abort();
        print_verdict();
    end
    // Tests need a few thousand cycles; allow 60000
    initial begin
        #1200000;
        failures++;
        print_verdict();
    end
endmodule
